/* File: include/gpp_defines.svh */
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// Register byte offsets within the port window
`define GPP_ADDR_W 8
`define GPP_OFS_MODE 8'h00
`define GPP_OFS_OTYPE 8'h04
`define GPP_OFS_PULL 8'h08
`define GPP_OFS_IDR 8'h0C
`define GPP_OFS_ODR 8'h10
`define GPP_OFS_SET 8'h14
`define GPP_OFS_CLR 8'h18

// Per-pin field layout
`define GPP_MODE_FIELD_W 2
`define GPP_PULL_FIELD_W 2
`define GPP_OTYPE_FIELD_W 1

// Reset images: plain port, all pins analog, no pulls
`define GPP_MODE_RST_PLAIN 32'hFFFFFFFF
`define GPP_PULL_RST_PLAIN 32'h00000000
// Debug port A: data/select 13 up, clock 14 down, test data in 15 up
`define GPP_MODE_RST_DBG_A 32'h03FFFFFF
`define GPP_PULL_RST_DBG_A 32'h64000000
// Debug port B: test data out 3 alternate, test reset 4 input up
`define GPP_MODE_RST_DBG_B 32'hFFFFFCBF
`define GPP_PULL_RST_DBG_B 32'h00000100
// Boot port: boot select on pin 0, input pull-down
`define GPP_MODE_RST_BOOT 32'hFFFFFFFC
`define GPP_PULL_RST_BOOT 32'h00000002
`define GPP_OTYPE_RST 32'h00000000
`define GPP_ODR_RST 32'h00000000

`endif

/* File: include/gpp_pkg.sv */
package gpp_pkg;

    typedef enum logic [1:0] {
        gpp_mode_input = 2'h0,
        gpp_mode_output = 2'h1,
        gpp_mode_alt = 2'h2,
        gpp_mode_analog = 2'h3
    } gpp_mode_t;

    typedef enum logic [1:0] {
        gpp_pull_none = 2'h0,
        gpp_pull_up = 2'h1,
        gpp_pull_down = 2'h2,
        gpp_pull_rsvd = 2'h3
    } gpp_pull_t;

    // What one pad cell asks of the analog pad
    typedef struct packed {
        logic drive;
        logic level;
        logic pull_up;
        logic pull_down;
    } gpp_pad_t;

    // Address phase held over into the data phase
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [3:0] lanes;
    } gpp_acc_t;

endpackage

/* File: design/gpp_pin_cell.sv */
module gpp_pin_cell
    import gpp_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire gpp_mode_t mode_in,
    input wire logic otype_in,
    input wire gpp_pull_t pull_in,
    input wire logic data_in,
    input wire logic alt_in,
    input wire logic pad_in,
    output gpp_pad_t pad_out,
    output logic rx_out
);

    logic [2:0] sync;
    logic level;
    gpp_pad_t next_pad;
    logic next_rx;

    wire is_analog = (mode_in == gpp_mode_analog);
    wire is_alt = (mode_in == gpp_mode_alt);
    wire is_drive_mode = (mode_in == gpp_mode_output) || is_alt;
    // Register data reaches the pad only in general output mode
    wire src = is_alt ? alt_in : data_in;
    // Open drain never drives high; push-pull drives both levels
    wire drive_now = is_drive_mode && (!otype_in || !src);
    wire level_now = is_drive_mode && !otype_in && src;
    // Input and analog leave the buffer off and ignore the type bit
    // Reserved pull code gives no pull; analog gives none at all
    wire up_now = !is_analog && (pull_in == gpp_pull_up);
    wire down_now = !is_analog && (pull_in == gpp_pull_down);

    assign next_pad = '{drive: drive_now, level: level_now,
                        pull_up: up_now, pull_down: down_now};
    // Receiver forced low in analog mode
    assign next_rx = is_analog ? 1'b0 : level;

    // Level accepted only once second and third stages agree
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync <= 3'h0;
            level <= 1'b0;
        end else begin
            sync <= {sync[1:0], pad_in};
            if (sync[1] == sync[2]) begin
                level <= sync[2];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pad_out <= '0;
            rx_out <= 1'b0;
        end else begin
            pad_out <= next_pad;
            rx_out <= next_rx;
        end
    end

endmodule

/* File: design/gpp_port.sv */
// Operation
// - Mode field: 00 input, 01 general output, 10 alternate, 11 analog.
// - Type bit: 0 push-pull, 1 open-drain; ignored in input and analog.
// - Pull field: 00 none, 01 pull-up, 10 pull-down, 11 reserved.
// - Input mode: buffer off, receiver on, pulls per pull field.
// - Analog: buffer and pulls off, receiver forced 0, input bit reads 0.
// - Input, output, alternate: pin level sampled into input data every clock; here input data follows only once two samples agree.
// - Open-drain: 0 drives low, 1 leaves pin undriven, never high.
// - Push-pull: 0 drives low, 1 drives high.
// - Alternate: buffer on, pin driven by peripheral signal, receiver on.
// - Output data reads last written value; affects pin only in output mode.
// - Open-drain pin level is readable through input data register.
// - Reset: alternates inactive, ordinary pins reset to analog.
// - Debug pins reset to debug function with their fixed pulls.
// - Boot-select pin resets to input with pull-down.
// - Set register sets, clear register clears, bits written one only.
// - Set or clear completes in one write, no read-modify-write.
// - Registers accept word, half-word and byte accesses.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`include "gpp_defines.svh"

module gpp_port
    import gpp_pkg::*;
#(
    parameter int PINS = 16,
    parameter logic [31:0] MODE_RST = `GPP_MODE_RST_DBG_A,
    parameter logic [31:0] PULL_RST = `GPP_PULL_RST_DBG_A,
    parameter logic [31:0] OTYPE_RST = `GPP_OTYPE_RST,
    parameter logic [31:0] ODR_RST = `GPP_ODR_RST
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe_n_out,
    output logic [PINS-1:0] pull_up_out,
    output logic [PINS-1:0] pull_down_out,
    input wire logic [PINS-1:0] alt_data_in,
    output logic [PINS-1:0] alt_rx_out
);

    logic [2*PINS-1:0] pin_mode_register;
    logic [PINS-1:0] output_type_register;
    logic [2*PINS-1:0] pull_select_register;
    logic [PINS-1:0] output_data_register;
    logic [PINS-1:0] input_data;
    gpp_pad_t pad [PINS];

    logic [2*PINS-1:0] next_mode;
    logic [PINS-1:0] next_otype;
    logic [2*PINS-1:0] next_pull;
    logic [PINS-1:0] next_odr;
    logic [31:0] next_rdata;

    gpp_acc_t acc;
    logic acc_valid;
    gpp_acc_t next_acc;

    // Address phase decode
    wire addr_take = hsel_in && htrans_in[1] && hready_in;
    wire [1:0] lo = haddr_in[1:0];
    wire [3:0] lanes_byte = 4'(4'h1 << lo);
    wire [3:0] lanes_half = lo[1] ? 4'hC : 4'h3;
    wire [3:0] lanes_word = 4'hF;
    // Sizes above a word are not used here; treated as a word
    wire [3:0] lanes_now = (hsize_in == 3'h0) ? lanes_byte :
                           (hsize_in == 3'h1) ? lanes_half : lanes_word;

    assign next_acc = '{write: hwrite_in,
                        addr: {haddr_in[`GPP_ADDR_W-1:2], 2'h0},
                        lanes: lanes_now};

    // Data phase write strobes
    wire wr_any = acc_valid && acc.write;
    wire [31:0] wmask = {{8{acc.lanes[3]}}, {8{acc.lanes[2]}},
                         {8{acc.lanes[1]}}, {8{acc.lanes[0]}}};
    wire [31:0] wbits = hwdata_in & wmask;

    wire wr_mode = wr_any && (acc.addr == `GPP_OFS_MODE);
    wire wr_otype = wr_any && (acc.addr == `GPP_OFS_OTYPE);
    wire wr_pull = wr_any && (acc.addr == `GPP_OFS_PULL);
    wire wr_odr = wr_any && (acc.addr == `GPP_OFS_ODR);
    wire wr_set = wr_any && (acc.addr == `GPP_OFS_SET);
    wire wr_clr = wr_any && (acc.addr == `GPP_OFS_CLR);

    wire [2*PINS-1:0] mode_merged =
        (pin_mode_register & ~wmask[2*PINS-1:0]) | wbits[2*PINS-1:0];
    wire [2*PINS-1:0] pull_merged =
        (pull_select_register & ~wmask[2*PINS-1:0]) | wbits[2*PINS-1:0];
    wire [PINS-1:0] otype_merged =
        (output_type_register & ~wmask[PINS-1:0]) | wbits[PINS-1:0];
    wire [PINS-1:0] odr_merged =
        (output_data_register & ~wmask[PINS-1:0]) | wbits[PINS-1:0];
    // Only bits written as one move; the rest hold in the same cycle
    wire [PINS-1:0] odr_set = output_data_register | wbits[PINS-1:0];
    wire [PINS-1:0] odr_clr = output_data_register & ~wbits[PINS-1:0];

    assign next_mode = wr_mode ? mode_merged : pin_mode_register;
    assign next_pull = wr_pull ? pull_merged : pull_select_register;
    assign next_otype = wr_otype ? otype_merged : output_type_register;
    // Single write transfer updates the bits, no read needed
    assign next_odr = wr_odr ? odr_merged :
                      wr_set ? odr_set :
                      wr_clr ? odr_clr : output_data_register;

    // Read mux looks at next values so a read straight after a write
    // sees the new contents without a wait state
    wire [`GPP_ADDR_W-1:0] rd_addr = {haddr_in[`GPP_ADDR_W-1:2], 2'h0};
    wire rd_mode = (rd_addr == `GPP_OFS_MODE);
    wire rd_otype = (rd_addr == `GPP_OFS_OTYPE);
    wire rd_pull = (rd_addr == `GPP_OFS_PULL);
    wire rd_idr = (rd_addr == `GPP_OFS_IDR);
    wire rd_odr = (rd_addr == `GPP_OFS_ODR);

    wire [31:0] rd_mode_val = 32'(next_mode);
    wire [31:0] rd_otype_val = 32'(next_otype);
    wire [31:0] rd_pull_val = 32'(next_pull);
    wire [31:0] rd_idr_val = 32'(input_data);
    wire [31:0] rd_odr_val = 32'(next_odr);

    // Set, clear and unmapped offsets read as zero
    assign next_rdata = rd_mode ? rd_mode_val :
                        rd_otype ? rd_otype_val :
                        rd_pull ? rd_pull_val :
                        rd_idr ? rd_idr_val :
                        rd_odr ? rd_odr_val : 32'h00000000;

    // Zero wait state slave, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc <= '0;
            acc_valid <= 1'b0;
        end else begin
            acc <= next_acc;
            acc_valid <= addr_take;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hrdata_out <= 32'h00000000;
        end else if (addr_take && !hwrite_in) begin
            hrdata_out <= next_rdata;
        end
    end

    // Reset images put debug and boot pins in their fixed state,
    // all other pins analog with alternates idle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_mode_register <= MODE_RST[2*PINS-1:0];
            pull_select_register <= PULL_RST[2*PINS-1:0];
            output_type_register <= OTYPE_RST[PINS-1:0];
            output_data_register <= ODR_RST[PINS-1:0];
        end else begin
            pin_mode_register <= next_mode;
            pull_select_register <= next_pull;
            output_type_register <= next_otype;
            output_data_register <= next_odr;
        end
    end

    // One pad cell per pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        gpp_pin_cell u_cell (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .mode_in(gpp_mode_t'(pin_mode_register[2*i +: 2])),
            .otype_in(output_type_register[i]),
            .pull_in(gpp_pull_t'(pull_select_register[2*i +: 2])),
            .data_in(output_data_register[i]),
            .alt_in(alt_data_in[i]),
            .pad_in(pad_in[i]),
            .pad_out(pad[i]),
            .rx_out(input_data[i])
        );
        assign pad_out[i] = pad[i].level;
        assign pad_oe_n_out[i] = !pad[i].drive;
        assign pull_up_out[i] = pad[i].pull_up;
        assign pull_down_out[i] = pad[i].pull_down;
        // Peripherals see the same receiver level as software
        assign alt_rx_out[i] = input_data[i];
    end

endmodule

/* File: dv/gpp_port_props.sv */
module gpp_port_props #(
    parameter int PINS = 16,
    parameter logic [31:0] MODE_RST = '0,
    parameter logic [31:0] PULL_RST = '0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [31:0] hrdata_out,
    input wire logic [PINS-1:0] pad_in,
    input wire logic [PINS-1:0] pull_up_out,
    input wire logic [PINS-1:0] pull_down_out,
    input wire logic [PINS-1:0] alt_rx_out
);
    function automatic logic [PINS-1:0] rst_pull(input logic [1:0] code);
        for (int i = 0; i < PINS; i++) begin
            rst_pull[i] = PULL_RST[2*i+:2] == code && MODE_RST[2*i+:2] != 2'h3;
        end
    endfunction
    wire logic take = hsel_in & htrans_in[1] & hreadyout_out;
    wire logic rd_take = take & ~hwrite_in;
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    chk_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus stalled or answered with error");
    chk_pull_excl: assert property ((pull_up_out & pull_down_out) == '0)
        else $error("pull-up and pull-down on together");
    chk_reset_pulls: assert property ($rose(nrst_in) |=>
        pull_up_out == rst_pull(2'h1) && pull_down_out == rst_pull(2'h2))
        else $error("pulls differ from reset image");
    // Two agreeing high samples are needed before the input bit may rise
    chk_sync_rise: assert property (((alt_rx_out & ~$past(alt_rx_out))
        & ~($past(pad_in, 4) & $past(pad_in, 5))) == '0)
        else $error("input bit rose without a settled high pin");
    chk_sync_low: assert property (($past(~pad_in, 4) & $past(~pad_in, 5) & alt_rx_out) == '0)
        else $error("input bit high for a settled low pin");
    chk_idr_read: assert property (rd_take && haddr_in[7:0] == 8'h0C |=>
        hrdata_out == 32'(alt_rx_out) || hrdata_out == 32'($past(alt_rx_out)))
        else $error("input data read differs from receiver");
    chk_wo_zero: assert property (rd_take && haddr_in[7:0] >= 8'h14 |=> hrdata_out == '0)
        else $error("write-only or unmapped read not zero");
    chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata_out))
        else $error("read data moved without a read");
    cover property (rd_take && haddr_in[7:0] == 8'h0C);
    cover property (take && hwrite_in && haddr_in[7:0] == 8'h14);
    cover property ($rose(alt_rx_out[5]));
endmodule

bind gpp_port gpp_port_props #(.PINS(PINS), .MODE_RST(MODE_RST), .PULL_RST(PULL_RST)) u_props (
    .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .hrdata_out(hrdata_out), .pad_in(pad_in),
    .pull_up_out(pull_up_out), .pull_down_out(pull_down_out), .alt_rx_out(alt_rx_out));

/* File: dv/gpp_pad_model.sv */
module gpp_pad_model #(
    parameter int PINS = 16
) (
    input wire logic clk_in,
    input wire logic [PINS-1:0] drive_in,
    input wire logic [PINS-1:0] oe_n_in,
    input wire logic [PINS-1:0] up_in,
    input wire logic [PINS-1:0] down_in,
    input wire logic [PINS-1:0] ext_en_in,
    input wire logic [PINS-1:0] ext_val_in,
    output logic [PINS-1:0] level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating pin wanders so that no reading of it can pass by luck
    logic [PINS-1:0] float_q = '0;
    always_ff @(posedge clk_in) begin
        float_q <= ~float_q;
    end
    // Strong outside drivers beat the weak pulls
    assign level_out = (~oe_n_in & drive_in) | (oe_n_in & ext_en_in & ext_val_in)
        | (oe_n_in & ~ext_en_in & (up_in | (~down_in & float_q)));
endmodule

/* File: dv/gpp_port_mode_and_bit_control_test.sv */
`include "gpp_defines.svh"

module gpp_port_mode_and_bit_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic hready, hresp;
    logic [15:0] pad_in, pad_out, oe_n, pu, pd, alt_rx;
    logic [15:0] alt_data = 16'h0020, ext_en = 16'h1FFF, ext_val = 16'h1FF7;
    logic [15:0] b_pu, b_pd, b_oe, b_rx;
    int fail_count = 0;
    int n_compared = 0;
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    gpp_port dut (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n_out(oe_n), .pull_up_out(pu),
        .pull_down_out(pd), .alt_data_in(alt_data), .alt_rx_out(alt_rx));
    gpp_pad_model pads (.clk_in(clk_in), .drive_in(pad_out), .oe_n_in(oe_n), .up_in(pu),
        .down_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
    // Boot port image: only reset state is examined, bus left idle
    gpp_port #(.MODE_RST(`GPP_MODE_RST_BOOT), .PULL_RST(`GPP_PULL_RST_BOOT)) dut_boot (
        .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(1'b0), .haddr_in(32'h00000000),
        .htrans_in(2'h0), .hwrite_in(1'b0), .hsize_in(3'h2), .hwdata_in(32'h00000000),
        .hready_in(1'b1), .hreadyout_out(), .hresp_out(), .hrdata_out(),
        .pad_in(16'hFFFF), .pad_out(), .pad_oe_n_out(b_oe), .pull_up_out(b_pu),
        .pull_down_out(b_pd), .alt_data_in(16'h0000), .alt_rx_out(b_rx));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [2:0] sz, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= sz;
        @(posedge clk_in iff hready === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_in iff hready === 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
        logic [31:0] q;
        xfer(1'b1, a, d, sz, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, '0, 3'h2, q);
        check(q, exp);
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Whole sequence needs about 60 cycles
    initial begin
        repeat (3000) @(posedge clk_in);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rd_chk(8'h00, 32'h03FFFFFF);
        rd_chk(8'h08, 32'h64000000);
        check({pu, pd}, 32'hA0004000);
        check(oe_n, 16'hFFFF);
        check(b_pd, 16'h0001);
        check(b_pu, 16'h0000);
        check(b_oe, 16'hFFFF);
        check(b_rx, 16'h0001);
        rd_chk(8'h0C, 32'h0000A000);
        // Pins 2 and 3 open-drain, pin 0 pulled down, pin 4 reserved pull
        wr(8'h04, 32'h0000000C);
        wr(8'h10, 32'h0000000A);
        wr(8'h08, 32'h64000302);
        wr(8'h00, 32'h03FFF855);
        repeat (8) @(posedge clk_in);
        check(oe_n[5:0], 6'h18);
        check(pad_out[5:0] & ~oe_n[5:0], 6'h22);
        check({pu, pd}, 32'hA0004001);
        rd_chk(8'h08, 32'h64000302);
        rd_chk(8'h0C, 32'h0000A032);
        check(alt_rx, 16'hA032);
        rd_chk(8'h10, 32'h0000000A);
        wr(8'h14, 32'h00000005);
        rd_chk(8'h10, 32'h0000000F);
        wr(8'h18, 32'h00000003);
        rd_chk(8'h10, 32'h0000000C);
        wr(8'h11, 32'h0000AB00, 3'h0);
        rd_chk(8'h10, 32'h0000AB0C);
        rd_chk(8'h14, 32'h00000000);
        rd_chk(8'h1C, 32'h00000000);
        check(oe_n[3:0], 4'hC);
        give_verdict();
    end
endmodule
